//--- hdl/pid_pkg.sv
`default_nettype none

package pid_pkg;

  // ****************************************
  // Prefix bytes
  // ****************************************
  localparam logic [7:0] PFX_SWAP_Y = 8'h90;
  localparam logic [7:0] PFX_IND_Y = 8'h91;
  localparam logic [7:0] PFX_IND = 8'h92;

  // ****************************************
  // Opcode layout: high nibble mode, low nibble operation
  // ****************************************
  localparam int OPC_MODE_MSB = 7;
  localparam int OPC_MODE_LSB = 4;
  localparam logic [3:0] MD_INH = 4'h4;
  localparam logic [3:0] MD_IMM = 4'ha;
  localparam logic [3:0] MD_DIR = 4'hb;
  localparam logic [3:0] MD_DIRL = 4'hc;
  localparam logic [3:0] MD_IDXL = 4'hd;
  localparam logic [3:0] MD_IDXS = 4'he;
  localparam logic [3:0] MD_IDX0 = 4'hf;
  localparam logic [3:0] OP_AND = 4'h4;
  localparam logic [3:0] OP_LD = 4'h6;
  localparam logic [3:0] OP_ADC = 4'h9;
  localparam logic [3:0] OP_NOP = 4'hd;

  // ****************************************
  // Condition code bit positions and reset values
  // ****************************************
  localparam int CC_C = 0;
  localparam int CC_Z = 1;
  localparam int CC_N = 2;
  localparam int CC_I = 3;
  localparam int CC_H = 4;
  localparam logic [4:0] CC_RST = 5'h00;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [15:0] EA_RST = 16'h0000;
  localparam logic [15:0] EA_SHORT_MAX = 16'h01fe;
  localparam logic [2:0] LEN_MIN = 3'h1;
  localparam logic [2:0] LEN_MAX = 3'h4;

  typedef enum logic [4:0] {
    S_FETCH = 5'b00001,
    S_EXT1 = 5'b00010,
    S_EXT2 = 5'b00100,
    S_CALC = 5'b01000,
    S_OPND = 5'b10000
  } pid_state_t;

  function automatic logic [1:0] pid_ext_bytes(input logic [3:0] md);
    unique case (md)
      MD_IMM, MD_DIR, MD_IDXS: pid_ext_bytes = 2'h1;
      MD_DIRL, MD_IDXL: pid_ext_bytes = 2'h2;
      default: pid_ext_bytes = 2'h0;
    endcase
  endfunction

  function automatic logic pid_is_prefix(input logic [7:0] b);
    pid_is_prefix = (b == PFX_SWAP_Y) || (b == PFX_IND_Y) || (b == PFX_IND);
  endfunction

  function automatic logic pid_is_opcode(input logic [7:0] b);
    logic [3:0] md;
    logic [3:0] op;
    md = b[OPC_MODE_MSB:OPC_MODE_LSB];
    op = b[OPC_MODE_LSB-1:0];
    if (md == MD_INH) begin
      pid_is_opcode = (op == OP_NOP);
    end else begin
      pid_is_opcode = (md >= MD_IMM) && ((op == OP_AND) || (op == OP_LD) || (op == OP_ADC));
    end
  endfunction

endpackage

`default_nettype wire

//--- hdl/pid_alu_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pid_alu_if;
  logic [7:0] a;
  logic [7:0] m;
  logic c_in;
  logic [3:0] op;
  logic [7:0] res;
  logic h;
  logic n;
  logic z;
  logic c;
  modport core(output a, m, c_in, op, input res, h, n, z, c);
  modport alu(input a, m, c_in, op, output res, h, n, z, c);
endinterface

`default_nettype wire

//--- hdl/pid_alu.sv
`timescale 1ns/1ps
`default_nettype none

module pid_alu import pid_pkg::*; (
  pid_alu_if.alu bus
);

  logic [8:0] sum;
  logic [4:0] half;

  always_comb begin
    sum = {1'b0, bus.a} + {1'b0, bus.m} + {8'h00, bus.c_in};
    half = {1'b0, bus.a[3:0]} + {1'b0, bus.m[3:0]} + {4'h0, bus.c_in};
    unique case (bus.op)
      OP_ADC: bus.res = sum[7:0];
      OP_AND: bus.res = bus.a & bus.m;
      default: bus.res = bus.m;
    endcase
    bus.c = sum[8];
    bus.h = half[4];
    bus.n = bus.res[7];
    bus.z = (bus.res == 8'h00);
  end

endmodule // pid_alu

`default_nettype wire

//--- hdl/pid_top.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Indexed address is index plus offset, unsigned
// - No-offset indexed: no extra byte, range 00-FF
// - Short indexed: one offset byte, range 00-1FE
// - Long indexed: two offset bytes, full space
// - Instructions are one to four bytes long
// - One optional prefix, then opcode, then 0-2 bytes
// - Prefix 90 swaps X for Y
// - Prefix 92 makes direct forms indirect
// - Prefix 92 makes X indexed indirect
// - Prefix 91 makes X indirect indexed use Y
// - Unknown opcode or prefix byte resets device
// - Known prefix with known opcode never resets
// - ADC adds with carry, sets H N Z C
// - AND updates accumulator, only N and Z
// - Inherent instructions are the opcode alone
module pid_top import pid_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_in,
  input wire logic [7:0] idx_x,
  input wire logic [7:0] idx_y,
  input wire logic opnd_valid,
  input wire logic [7:0] opnd_in,
  output logic byte_ready_r,
  output logic [15:0] ea_r,
  output logic ea_valid_r,
  output logic use_y_r,
  output logic indirect_r,
  output logic [7:0] opc_r,
  output logic [2:0] instr_len_r,
  output logic instr_done_r,
  output logic illegal_rst_r,
  output logic [7:0] acc_r,
  output logic [4:0] cc_r
);

  // ****************************************
  // Reset release
  // ****************************************
  logic rst_s1_r;
  logic rst_s2_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // ****************************************
  // Decode state
  // ****************************************
  pid_state_t state_r, state_nxt;
  logic [7:0] pfx_r, pfx_nxt;
  logic pfx_v_r, pfx_v_nxt;
  logic [15:0] ofs_r, ofs_nxt;
  logic [15:0] ea_nxt;
  logic ea_valid_nxt, use_y_nxt, indirect_nxt, byte_ready_nxt;
  logic [7:0] opc_nxt, acc_nxt;
  logic [2:0] len_nxt;
  logic done_nxt, ill_nxt;
  logic [4:0] cc_nxt;
  logic take, exec_go;
  logic [3:0] md_in, md_r;
  logic [7:0] idx_sel;
  pid_alu_if alu_bus ();

  pid_alu u_alu (
    .bus(alu_bus)
  );

  assign take = byte_valid && byte_ready_r;
  assign md_in = byte_in[OPC_MODE_MSB:OPC_MODE_LSB];
  assign md_r = opc_r[OPC_MODE_MSB:OPC_MODE_LSB];
  assign idx_sel = use_y_r ? idx_y : idx_x;
  assign exec_go = ((state_r == S_CALC) && (md_r == MD_IMM)) || ((state_r == S_OPND) && opnd_valid);
  assign alu_bus.a = acc_r;
  assign alu_bus.m = (state_r == S_OPND) ? opnd_in : ofs_r[7:0];
  assign alu_bus.c_in = cc_r[CC_C];
  assign alu_bus.op = opc_r[OPC_MODE_LSB-1:0];

  // ****************************************
  // Next state and datapath
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    pfx_nxt = pfx_r;
    pfx_v_nxt = pfx_v_r;
    ofs_nxt = ofs_r;
    ea_nxt = ea_r;
    ea_valid_nxt = 1'b0;
    use_y_nxt = use_y_r;
    indirect_nxt = indirect_r;
    opc_nxt = opc_r;
    len_nxt = instr_len_r;
    done_nxt = 1'b0;
    ill_nxt = 1'b0;
    acc_nxt = acc_r;
    cc_nxt = cc_r;
    unique case (state_r)
      S_FETCH: begin
        if (take && pid_is_prefix(byte_in)) begin
          pfx_nxt = byte_in;
          pfx_v_nxt = 1'b1;
        end else if (take && pid_is_opcode(byte_in)) begin
          // A prefix before a legal opcode never resets, even if unused
          opc_nxt = byte_in;
          ofs_nxt = EA_RST;
          len_nxt = pfx_v_r ? 3'h2 : LEN_MIN;
          use_y_nxt = pfx_v_r && (((pfx_r == PFX_SWAP_Y) && (md_in != MD_DIRL))
                      || ((pfx_r == PFX_IND_Y) && (md_in >= MD_IDXL)));
          indirect_nxt = pfx_v_r && (((pfx_r == PFX_IND) && (md_in >= MD_DIR))
                         || ((pfx_r == PFX_IND_Y) && (md_in >= MD_IDXL)));
          state_nxt = (pid_ext_bytes(md_in) == 2'h0) ? S_CALC : S_EXT1;
        end else if (take) begin
          ill_nxt = 1'b1;
          pfx_v_nxt = 1'b0;
          acc_nxt = ACC_RST;
          cc_nxt = CC_RST;
          len_nxt = 3'h0;
        end
      end
      S_EXT1: begin
        if (take) begin
          ofs_nxt = {8'h00, byte_in};
          len_nxt = instr_len_r + 3'h1;
          state_nxt = (pid_ext_bytes(md_r) == 2'h2) ? S_EXT2 : S_CALC;
        end
      end
      S_EXT2: begin
        if (take) begin
          ofs_nxt = {ofs_r[7:0], byte_in};
          len_nxt = instr_len_r + 3'h1;
          state_nxt = S_CALC;
        end
      end
      S_CALC: begin
        // Indirect forms hand out the pointer address; the pointer fetch is outside
        if (md_r >= MD_IDXL) begin
          ea_nxt = ofs_r + {8'h00, idx_sel};
        end else begin
          ea_nxt = ofs_r;
        end
        if ((md_r == MD_INH) || (md_r == MD_IMM)) begin
          done_nxt = 1'b1;
          pfx_v_nxt = 1'b0;
          state_nxt = S_FETCH;
        end else begin
          ea_valid_nxt = 1'b1;
          state_nxt = S_OPND;
        end
      end
      S_OPND: begin
        if (opnd_valid) begin
          done_nxt = 1'b1;
          pfx_v_nxt = 1'b0;
          state_nxt = S_FETCH;
        end
      end
    endcase
    if (exec_go && (alu_bus.op != OP_NOP)) begin
      acc_nxt = alu_bus.res;
      cc_nxt[CC_N] = alu_bus.n;
      cc_nxt[CC_Z] = alu_bus.z;
      if (alu_bus.op == OP_ADC) begin
        cc_nxt[CC_H] = alu_bus.h;
        cc_nxt[CC_C] = alu_bus.c;
      end
    end
    byte_ready_nxt = (state_nxt == S_FETCH) || (state_nxt == S_EXT1) || (state_nxt == S_EXT2);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      state_r <= S_FETCH;
      pfx_r <= 8'h00;
      pfx_v_r <= 1'b0;
      ofs_r <= EA_RST;
      ea_r <= EA_RST;
      ea_valid_r <= 1'b0;
      use_y_r <= 1'b0;
      indirect_r <= 1'b0;
      opc_r <= 8'h00;
      instr_len_r <= 3'h0;
      instr_done_r <= 1'b0;
      illegal_rst_r <= 1'b0;
      acc_r <= ACC_RST;
      cc_r <= CC_RST;
      byte_ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pfx_r <= pfx_nxt;
      pfx_v_r <= pfx_v_nxt;
      ofs_r <= ofs_nxt;
      ea_r <= ea_nxt;
      ea_valid_r <= ea_valid_nxt;
      use_y_r <= use_y_nxt;
      indirect_r <= indirect_nxt;
      opc_r <= opc_nxt;
      instr_len_r <= len_nxt;
      instr_done_r <= done_nxt;
      illegal_rst_r <= ill_nxt;
      acc_r <= acc_nxt;
      cc_r <= cc_nxt;
      byte_ready_r <= byte_ready_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s2_r);

  a_index_sum: assert property (
    ea_valid_r && (md_r >= MD_IDXL) |->
      ea_r == ofs_r + {8'h00, (use_y_r ? $past(idx_y) : $past(idx_x))})
    else $error("indexed address is not index plus offset");
  a_nooffs_range: assert property (
    ea_valid_r && (md_r == MD_IDX0) |-> ea_r[15:8] == 8'h00 && instr_len_r <= 3'h2)
    else $error("no-offset indexed address out of range");
  a_short_range: assert property (
    ea_valid_r && (md_r == MD_IDXS) |-> ea_r <= EA_SHORT_MAX)
    else $error("short indexed address out of range");
  a_long_bytes: assert property (
    (state_r == S_EXT2) && take |=> ofs_r == {$past(ofs_r[7:0]), $past(byte_in)})
    else $error("long offset not assembled high then low");
  a_len_bounds: assert property (
    instr_done_r |-> instr_len_r >= LEN_MIN && instr_len_r <= LEN_MAX)
    else $error("instruction length outside one to four");
  a_swap_y: assert property (
    (state_r == S_FETCH) && take && pfx_v_r && (pfx_r == PFX_SWAP_Y) && pid_is_opcode(byte_in)
      && (md_in == MD_IDX0) |=> use_y_r && !indirect_r)
    else $error("prefix 90 did not select Y");
  a_ind_form: assert property (
    (state_r == S_FETCH) && take && pfx_v_r && (pfx_r == PFX_IND) && pid_is_opcode(byte_in)
      && (md_in >= MD_DIR) |=> indirect_r && !use_y_r)
    else $error("prefix 92 did not select indirect form");
  a_ind_y: assert property (
    (state_r == S_FETCH) && take && pfx_v_r && (pfx_r == PFX_IND_Y) && pid_is_opcode(byte_in)
      && (md_in >= MD_IDXL) |=> indirect_r && use_y_r)
    else $error("prefix 91 did not select Y indirect");
  a_illegal_rst: assert property (
    (state_r == S_FETCH) && take && !pid_is_prefix(byte_in) && !pid_is_opcode(byte_in) |=>
      illegal_rst_r && acc_r == ACC_RST && !pfx_v_r ##1 !illegal_rst_r)
    else $error("unknown byte did not reset");
  a_pfx_no_rst: assert property (
    (state_r == S_FETCH) && take && pfx_v_r && pid_is_opcode(byte_in) |=> !illegal_rst_r)
    else $error("prefixed opcode caused a reset");
  a_adc_result: assert property (
    exec_go && (alu_bus.op == OP_ADC) |=>
      {cc_r[CC_C], acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(alu_bus.m)}
        + {8'h00, $past(cc_r[CC_C])} && $stable(cc_r[CC_I]))
    else $error("add with carry result wrong");
  a_and_result: assert property (
    exec_go && (alu_bus.op == OP_AND) |=>
      acc_r == ($past(acc_r) & $past(alu_bus.m)) && $stable(cc_r[CC_C]) && $stable(cc_r[CC_H]))
    else $error("logical and result or flags wrong");
  a_inh_len: assert property (
    instr_done_r && (md_r == MD_INH) && !use_y_r && !indirect_r |-> instr_len_r <= 3'h2)
    else $error("inherent instruction took extra bytes");
  a_pfx_clear: assert property (
    instr_done_r |-> !pfx_v_r)
    else $error("prefix still pending after instruction");
  a_inh_one: assert property (
    instr_done_r && (md_r == MD_INH) && !$past(pfx_v_r) |-> instr_len_r == LEN_MIN)
    else $error("unprefixed inherent instruction is not one byte");
  a_ext_len: assert property (
    instr_done_r |-> instr_len_r == ($past(pfx_v_r) ? 3'h2 : LEN_MIN) + {1'b0, pid_ext_bytes(md_r)})
    else $error("instruction length does not match its mode");
  a_no_extra: assert property (
    (state_r == S_CALC) || (state_r == S_OPND) |-> !byte_ready_r)
    else $error("byte accepted after the address bytes");
  a_done_pulse: assert property (
    instr_done_r |=> !instr_done_r)
    else $error("completion lasted more than one cycle");
  a_ea_pulse: assert property (
    ea_valid_r |=> !ea_valid_r)
    else $error("address valid lasted more than one cycle");
  a_y_ind_only: assert property (
    (state_r == S_FETCH) && take && pfx_v_r && (pfx_r == PFX_IND_Y) && pid_is_opcode(byte_in)
      && (md_in < MD_IDXL) |=> !use_y_r && !indirect_r && !illegal_rst_r)
    else $error("prefix 91 changed a non-indexed instruction");

  c_pfx_idx: cover property (ea_valid_r && use_y_r && (md_r >= MD_IDXL));
  c_illegal: cover property (illegal_rst_r);
  c_adc_done: cover property (instr_done_r && (alu_bus.op == OP_ADC));
  c_long_four: cover property (instr_done_r && (instr_len_r == LEN_MAX));
  c_ind_y: cover property (ea_valid_r && indirect_r && use_y_r);

endmodule // pid_top

`default_nettype wire

//--- testbench/pid_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Program memory and operand source model
// ****************************************
module pid_prog_mem (
  input wire logic clk,
  input wire logic byte_ready_r,
  input wire logic ea_valid_r,
  input wire logic instr_done_r,
  input wire logic [7:0] opnd_data,
  input wire logic [1:0] lat,
  output logic byte_valid,
  output logic [7:0] byte_in,
  output logic opnd_valid,
  output logic [7:0] opnd_in
);
  logic [7:0] prog[$];
  logic armed = 1'b0;
  logic [1:0] cnt = 2'h0;

  initial begin
    byte_valid = 1'b0;
    byte_in = 8'h00;
    opnd_valid = 1'b0;
    opnd_in = 8'h00;
  end

  // Bytes go out in order; the front is dropped once taken
  always @(posedge clk) begin
    if (byte_valid && byte_ready_r) begin
      void'(prog.pop_front());
    end
    byte_valid <= prog.size() != 0;
    byte_in <= (prog.size() != 0) ? prog[0] : ~byte_in;
  end

  // Operand answers after a chosen wait and holds until completion is seen
  always @(posedge clk) begin
    if (instr_done_r) begin
      armed <= 1'b0;
    end else if (ea_valid_r) begin
      armed <= 1'b1;
      cnt <= lat;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end
    opnd_valid <= armed && cnt == 2'h0 && !instr_done_r;
    opnd_in <= (armed && cnt == 2'h0 && !instr_done_r) ? opnd_data : ~opnd_in;
  end
endmodule // pid_prog_mem

`default_nettype wire

//--- testbench/prebyte_indexed_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none

module prebyte_indexed_decoder_tb;
  typedef struct {logic chk; logic [15:0] ea; logic y; logic ind;} pid_ea_note_t;
  typedef struct {logic ill; logic [7:0] acc; logic [4:0] cc; logic [2:0] len; logic [7:0] opc;} pid_done_note_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] idx_x = 8'h00;
  logic [7:0] idx_y = 8'h00;
  logic [7:0] opnd_data = 8'h00;
  logic [1:0] lat = 2'h0;
  logic byte_valid, opnd_valid, byte_ready_r, ea_valid_r, use_y_r, indirect_r;
  logic instr_done_r, illegal_rst_r;
  logic [7:0] byte_in, opnd_in, opc_r, acc_r;
  logic [15:0] ea_r;
  logic [2:0] instr_len_r;
  logic [4:0] cc_r;
  int n_errors = 0;
  int checked = 0;
  logic [7:0] seed = 8'h52;
  logic [7:0] m_acc = 8'h00;
  logic [4:0] m_cc = 5'h00;
  pid_ea_note_t eq[$];
  pid_done_note_t dq[$];

  pid_top dut (.clk(clk), .nrst(nrst), .byte_valid(byte_valid), .byte_in(byte_in),
    .idx_x(idx_x), .idx_y(idx_y), .opnd_valid(opnd_valid), .opnd_in(opnd_in),
    .byte_ready_r(byte_ready_r), .ea_r(ea_r), .ea_valid_r(ea_valid_r), .use_y_r(use_y_r),
    .indirect_r(indirect_r), .opc_r(opc_r), .instr_len_r(instr_len_r),
    .instr_done_r(instr_done_r), .illegal_rst_r(illegal_rst_r), .acc_r(acc_r), .cc_r(cc_r));
  pid_prog_mem u_mem (.clk(clk), .byte_ready_r(byte_ready_r), .ea_valid_r(ea_valid_r),
    .instr_done_r(instr_done_r), .opnd_data(opnd_data), .lat(lat), .byte_valid(byte_valid),
    .byte_in(byte_in), .opnd_valid(opnd_valid), .opnd_in(opnd_in));

  initial begin
    forever #50 clk = ~clk;
  end

  function automatic logic [7:0] rnd();
    seed = {seed[6:0], ^(seed & 8'hb8)};
    return seed;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Instruction driver with reference model
  // ****************************************
  task automatic run(input logic hp, input logic [7:0] p, input logic [7:0] o,
                     input logic [15:0] ext, input logic [7:0] xv, input logic [7:0] yv);
    logic [3:0] md, op;
    logic [1:0] n;
    logic [15:0] off;
    logic [7:0] m, r;
    logic [8:0] s;
    logic leg, h;
    int i;
    pid_ea_note_t e;
    md = o[7:4];
    op = o[3:0];
    r = rnd();
    leg = (o == 8'h4d) || (md >= 4'ha && (op == 4'h4 || op == 4'h6 || op == 4'h9));
    n = (md == 4'hc || md == 4'hd) ? 2'h2 : (md >= 4'ha && md <= 4'he) ? 2'h1 : 2'h0;
    e.y = hp && ((p == 8'h90 && md != 4'hc) || (p == 8'h91 && md >= 4'hd));
    e.ind = hp && ((p == 8'h92 && md >= 4'hb) || (p == 8'h91 && md >= 4'hd));
    off = (n == 2'h2) ? ext : (n == 2'h1) ? {8'h00, ext[7:0]} : 16'h0000;
    e.ea = (md >= 4'hd) ? off + {8'h00, (e.y ? yv : xv)} : off;
    e.chk = !(e.ind && md >= 4'hd);
    m = (md == 4'ha) ? ext[7:0] : r;
    @(posedge clk);
    idx_x <= xv;
    idx_y <= yv;
    opnd_data <= r;
    lat <= seed[1:0];
    if (!leg) begin
      m_acc = 8'h00;
      m_cc = 5'h00;
      dq.push_back('{1'b1, 8'h00, 5'h00, 3'h0, o});
    end else begin
      if (op == 4'h9) begin
        s = {1'b0, m_acc} + {1'b0, m} + {8'h00, m_cc[0]};
        h = ({1'b0, m_acc[3:0]} + {1'b0, m[3:0]} + {4'h0, m_cc[0]}) > 5'h0f;
        m_acc = s[7:0];
        m_cc = {h, m_cc[3], s[7], s[7:0] == 8'h00, s[8]};
      end else if (op == 4'h4 || op == 4'h6) begin
        m_acc = (op == 4'h4) ? (m_acc & m) : m;
        m_cc[2:1] = {m_acc[7], m_acc == 8'h00};
      end
      if (md >= 4'hb) eq.push_back(e);
      dq.push_back('{1'b0, m_acc, m_cc, 3'(hp) + 3'h1 + 3'(n), o});
    end
    if (hp) u_mem.prog.push_back(p);
    u_mem.prog.push_back(o);
    if (leg && n == 2'h2) u_mem.prog.push_back(ext[15:8]);
    if (leg && n != 2'h0) u_mem.prog.push_back(ext[7:0]);
    for (i = 0; i < 60 && !(instr_done_r === 1'b1 || illegal_rst_r === 1'b1); i++) @(posedge clk);
    check("completion_wait", 16'(i < 60), 16'h1);
    @(posedge clk);
  endtask

  // ****************************************
  // Output watcher
  // ****************************************
  always @(posedge clk) begin
    pid_ea_note_t e;
    pid_done_note_t d;
    if (nrst && ea_valid_r === 1'b1) begin
      if (eq.size() == 0) check("ea_note", 16'h0, 16'h1);
      else begin
        e = eq.pop_front();
        if (e.chk) check("ea", ea_r, e.ea);
        check("use_y", 16'(use_y_r), 16'(e.y));
        check("indirect", 16'(indirect_r), 16'(e.ind));
      end
    end
    if (nrst && (instr_done_r === 1'b1 || illegal_rst_r === 1'b1)) begin
      if (dq.size() == 0) check("done_note", 16'h0, 16'h1);
      else begin
        d = dq.pop_front();
        check("illegal", 16'(illegal_rst_r), 16'(d.ill));
        check("acc", 16'(acc_r), 16'(d.acc));
        check("cc", 16'(cc_r), 16'(d.cc));
        check("len", 16'(instr_len_r), 16'(d.len));
        if (!d.ill) check("opcode", 16'(opc_r), 16'(d.opc));
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  initial begin
    logic [7:0] r, o;
    logic [7:0] bad[6];
    bad = '{8'h00, 8'h93, 8'ha0, 8'h4e, 8'h5d, 8'hff};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    run(1'b0, 8'h00, 8'ha9, 16'h00c7, 8'h00, 8'h00);
    run(1'b0, 8'h00, 8'h4d, 16'h0000, 8'h00, 8'h00);
    run(1'b0, 8'h00, 8'hf9, 16'h0000, 8'h37, 8'hc1);
    run(1'b1, 8'h90, 8'hf9, 16'h0000, 8'h37, 8'hc1);
    run(1'b0, 8'h00, 8'hf4, 16'h0000, 8'h37, 8'hc1);
    run(1'b0, 8'h00, 8'he9, 16'h00ff, 8'hff, 8'h00);
    run(1'b1, 8'h90, 8'he6, 16'h0080, 8'h00, 8'hff);
    run(1'b0, 8'h00, 8'hd9, 16'hff00, 8'hff, 8'h00);
    run(1'b0, 8'h00, 8'hb4, 16'h0042, 8'h11, 8'h22);
    run(1'b0, 8'h00, 8'hc6, 16'h1234, 8'h11, 8'h22);
    run(1'b1, 8'h92, 8'hb9, 16'h0055, 8'h11, 8'h22);
    run(1'b1, 8'h92, 8'hc9, 16'h4321, 8'h11, 8'h22);
    run(1'b1, 8'h92, 8'he9, 16'h0010, 8'h11, 8'h22);
    run(1'b1, 8'h91, 8'hd6, 16'h0100, 8'h11, 8'h22);
    run(1'b1, 8'h91, 8'hb9, 16'h0033, 8'h11, 8'h22);
    run(1'b1, 8'h90, 8'hc4, 16'h2222, 8'h11, 8'h22);
    foreach (bad[k]) run(1'b0, 8'h00, bad[k], 16'h0000, 8'h00, 8'h00);
    run(1'b1, 8'h90, 8'h00, 16'h0000, 8'h00, 8'h00);
    repeat (30) begin
      r = rnd();
      o = {4'ha + 4'(r % 6), (r[7:6] == 2'h0) ? 4'h4 : (r[7] ? 4'h9 : 4'h6)};
      run(r[5], (r[4:3] == 2'h1) ? 8'h91 : (r[4] ? 8'h92 : 8'h90), o, {rnd() & 8'h7f, rnd()},
          rnd(), rnd());
    end
    check("ea_left", 16'(eq.size()), 16'h0000);
    check("done_left", 16'(dq.size()), 16'h0000);
    nrst <= 1'b0;
    @(negedge clk);
    check("acc_reset", 16'(acc_r), 16'h0000);
    check("ready_reset", 16'(byte_ready_r), 16'h0000);
    wrap_up();
  end
endmodule // prebyte_indexed_decoder_tb

`default_nettype wire
